/* File: port_ctrl_pkg.sv */
/*
 * Constants and carrier types for the per-port transmit rate control and
 * auto-negotiation control bank of a three-port switch.
 * Assumes an 8-bit register address space with one byte per register.
 */
package port_ctrl_pkg;

    localparam int NUM_PORTS    = 3;
    localparam int NUM_AN_PORTS = 2;

    // Register byte offsets.
    localparam logic [7:0] OFS_P1_RATE    = 8'h1b;
    localparam logic [7:0] OFS_P2_RATE    = 8'h2b;
    localparam logic [7:0] OFS_P3_RATE    = 8'h3b;
    localparam logic [7:0] OFS_P1_AN      = 8'h1c;
    localparam logic [7:0] OFS_P2_AN      = 8'h2c;
    localparam logic [7:0] OFS_P3_AN_RSVD = 8'h3c;

    // Transmit rate control field positions inside the rate register.
    localparam int RATE_DIFF_BIT  = 2;
    localparam int RATE_LO_EN_BIT = 1;
    localparam int RATE_HI_EN_BIT = 0;

    // Reset values.
    localparam logic [7:0] RATE_RESET    = 8'h00;
    localparam logic [7:0] AN_RESET      = 8'h0f;
    localparam logic [7:0] RDATA_RESET   = 8'h00;
    localparam logic [7:0] RSVD_READ     = 8'h00;
    localparam logic       ADV_100_RESET = 1'b1;
    localparam logic       ADV_10_RESET  = 1'b1;

    // Positions of the straps in the synchronised strap vector.
    localparam int STRAP_WIDTH    = 7;
    localparam int STRAP_P1_AN    = 0;
    localparam int STRAP_P1_SPEED = 1;
    localparam int STRAP_P1_DPX   = 2;
    localparam int STRAP_P2_AN    = 3;
    localparam int STRAP_P2_SPEED = 4;
    localparam int STRAP_P2_DPX   = 5;
    localparam int STRAP_PAUSE    = 6;

    // Field order matches bits 7 down to 0 of the auto-negotiation register.
    typedef struct packed {
        logic an_en;
        logic force_100;
        logic force_full;
        logic adv_pause;
        logic adv_100fd;
        logic adv_100hd;
        logic adv_10fd;
        logic adv_10hd;
    } an_ctrl_s;

    typedef struct packed {
        logic rate_en;
        logic use_high;
    } tx_rate_sel_s;

    typedef struct packed {
        logic use_forced_speed;
        logic use_forced_duplex;
        logic speed_100;
        logic full_duplex;
    } phy_mode_s;

    typedef enum logic [1:0] {
        INIT_SYNC1 = 2'b00,
        INIT_SYNC2 = 2'b01,
        INIT_LOAD  = 2'b10,
        INIT_RUN   = 2'b11
    } init_state_e;

endpackage

/* File: port_rate_an_ctrl.sv */
/*
 * Per-port transmit rate control selection and auto-negotiation control
 * registers, all reachable by the register port; the MII management port reaches only the negotiation ones.
 * Assumes register and management requests, packet priority and the
 * negotiation failure flag come from logic on clk; strap pins are async.
 */
`timescale 1ns/1ps

module port_rate_an_ctrl (
    input  wire  logic                                  clk,
    input  wire  logic                                  reset_n,
    input  wire  logic                                  ce,
    input  wire  logic [7:0]                            reg_addr,
    input  wire  logic                                  reg_wr,
    input  wire  logic                                  reg_rd,
    input  wire  logic [7:0]                            reg_wdata,
    output logic       [7:0]                            reg_rdata,
    input  wire  logic                                  miim_port_sel,
    input  wire  logic                                  miim_wr,
    input  wire  logic                                  miim_rd,
    input  wire  logic [7:0]                            miim_wdata,
    output logic       [7:0]                            miim_rdata,
    input  wire  logic                                  port1_autoneg_strap,
    input  wire  logic                                  port1_speed_strap,
    input  wire  logic                                  port1_duplex_strap,
    input  wire  logic                                  port2_autoneg_strap,
    input  wire  logic                                  port2_speed_strap,
    input  wire  logic                                  port2_duplex_strap,
    input  wire  logic                                  advertise_pause_strap,
    input  wire  logic [2:0]                            tx_high_prio,
    input  wire  logic [1:0]                            an_failed,
    output port_ctrl_pkg::tx_rate_sel_s [2:0]           tx_rate_sel,
    output port_ctrl_pkg::an_ctrl_s     [1:0]           an_ctrl,
    output port_ctrl_pkg::phy_mode_s    [1:0]           phy_mode,
    output logic                                        config_ready
);
    import port_ctrl_pkg::*;

    logic         [STRAP_WIDTH-1:0] strap_meta_q;
    logic         [STRAP_WIDTH-1:0] strap_sync_q;
    init_state_e                    state_q;
    init_state_e                    state_d;
    logic         [2:0][7:0]        rate_q;
    logic         [2:0][7:0]        rate_d;
    an_ctrl_s     [1:0]             an_q;
    an_ctrl_s     [1:0]             an_d;
    logic         [7:0]             reg_rdata_q;
    logic         [7:0]             reg_rdata_d;
    logic         [7:0]             miim_rdata_q;
    logic         [7:0]             miim_rdata_d;
    tx_rate_sel_s [2:0]             tx_rate_sel_q;
    tx_rate_sel_s [2:0]             tx_rate_sel_d;
    phy_mode_s    [1:0]             phy_mode_q;
    phy_mode_s    [1:0]             phy_mode_d;

    // Picks the counter set and enable for one egress packet.
    function automatic tx_rate_sel_s rate_select(input logic [7:0] ctrl,
                                                 input logic       high);
        tx_rate_sel_s sel;
        sel = '0;
        if (ctrl[RATE_DIFF_BIT] && high) begin
            sel.use_high = 1'b1;
            sel.rate_en  = ctrl[RATE_HI_EN_BIT];
        end else begin
            sel.use_high = 1'b0;
            sel.rate_en  = ctrl[RATE_LO_EN_BIT];
        end
        return sel;
    endfunction

    // Builds a negotiation register value from the sampled straps.
    function automatic an_ctrl_s strap_value(input logic an_en,
                                             input logic spd,
                                             input logic dpx,
                                             input logic pause);
        an_ctrl_s v;
        v            = AN_RESET;
        v.an_en      = an_en;
        v.force_100  = spd;
        v.force_full = dpx;
        v.adv_pause  = pause;
        v.adv_100fd  = ADV_100_RESET;
        v.adv_100hd  = ADV_100_RESET;
        v.adv_10fd   = ADV_10_RESET;
        v.adv_10hd   = ADV_10_RESET;
        return v;
    endfunction

    // The strap pins are held in place by resistors, so two stages suffice.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta_q <= '0;
            strap_sync_q <= '0;
        end else if (ce) begin
            strap_meta_q <= {advertise_pause_strap, port2_duplex_strap,
                             port2_speed_strap, port2_autoneg_strap,
                             port1_duplex_strap, port1_speed_strap,
                             port1_autoneg_strap};
            strap_sync_q <= strap_meta_q;
        end
    end

    always_comb begin
        state_d      = state_q;
        rate_d       = rate_q;
        an_d         = an_q;
        reg_rdata_d  = reg_rdata_q;
        miim_rdata_d = miim_rdata_q;
        case (state_q)
            INIT_SYNC1: begin
                state_d = INIT_SYNC2;
            end
            INIT_SYNC2: begin
                state_d = INIT_LOAD;
            end
            INIT_LOAD: begin
                an_d[0] = strap_value(strap_sync_q[STRAP_P1_AN],
                                      strap_sync_q[STRAP_P1_SPEED],
                                      strap_sync_q[STRAP_P1_DPX],
                                      strap_sync_q[STRAP_PAUSE]);
                an_d[1] = strap_value(strap_sync_q[STRAP_P2_AN],
                                      strap_sync_q[STRAP_P2_SPEED],
                                      strap_sync_q[STRAP_P2_DPX],
                                      strap_sync_q[STRAP_PAUSE]);
                state_d = INIT_RUN;
            end
            INIT_RUN: begin
                if (miim_wr) begin
                    an_d[miim_port_sel] = miim_wdata;
                end
                // The register port is applied last, so it wins a collision.
                if (reg_wr) begin
                    if (reg_addr == OFS_P1_RATE) begin
                        rate_d[0] = reg_wdata;
                    end else if (reg_addr == OFS_P2_RATE) begin
                        rate_d[1] = reg_wdata;
                    end else if (reg_addr == OFS_P3_RATE) begin
                        rate_d[2] = reg_wdata;
                    end else if (reg_addr == OFS_P1_AN) begin
                        an_d[0] = reg_wdata;
                    end else if (reg_addr == OFS_P2_AN) begin
                        an_d[1] = reg_wdata;
                    end
                end
            end
            default: begin
                state_d = INIT_RUN;
            end
        endcase
        if (reg_rd) begin
            if (reg_addr == OFS_P1_RATE) begin
                reg_rdata_d = rate_q[0];
            end else if (reg_addr == OFS_P2_RATE) begin
                reg_rdata_d = rate_q[1];
            end else if (reg_addr == OFS_P3_RATE) begin
                reg_rdata_d = rate_q[2];
            end else if (reg_addr == OFS_P1_AN) begin
                reg_rdata_d = an_q[0];
            end else if (reg_addr == OFS_P2_AN) begin
                reg_rdata_d = an_q[1];
            end else begin
                reg_rdata_d = RSVD_READ;
            end
        end
        if (miim_rd) begin
            miim_rdata_d = an_q[miim_port_sel];
        end
    end

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            tx_rate_sel_d[p] = rate_select(rate_q[p], tx_high_prio[p]);
        end
        for (int p = 0; p < NUM_AN_PORTS; p++) begin
            // forced mode when negotiation is off
            phy_mode_d[p].use_forced_speed  = !an_q[p].an_en;
            // forced duplex also covers a failed negotiation
            phy_mode_d[p].use_forced_duplex = !an_q[p].an_en || an_failed[p];
            phy_mode_d[p].speed_100         = an_q[p].force_100;
            phy_mode_d[p].full_duplex       = an_q[p].force_full;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q       <= INIT_SYNC1;
            rate_q        <= {NUM_PORTS{RATE_RESET}};
            an_q          <= {NUM_AN_PORTS{AN_RESET}};
            reg_rdata_q   <= RDATA_RESET;
            miim_rdata_q  <= RDATA_RESET;
            tx_rate_sel_q <= '0;
            phy_mode_q    <= '0;
        end else if (ce) begin
            state_q       <= state_d;
            rate_q        <= rate_d;
            an_q          <= an_d;
            reg_rdata_q   <= reg_rdata_d;
            miim_rdata_q  <= miim_rdata_d;
            tx_rate_sel_q <= tx_rate_sel_d;
            phy_mode_q    <= phy_mode_d;
        end
    end

    // advertised abilities driven from the register
    assign an_ctrl      = an_q;
    assign reg_rdata    = reg_rdata_q;
    assign miim_rdata   = miim_rdata_q;
    assign tx_rate_sel  = tx_rate_sel_q;
    assign phy_mode     = phy_mode_q;
    assign config_ready = (state_q == INIT_RUN);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_load_cycle;
        ce && (state_q == INIT_LOAD);
    endsequence

    sequence s_p1_an_write;
        ce && config_ready && reg_wr && (reg_addr == OFS_P1_AN);
    endsequence

    property p_strap_load;
        s_load_cycle |=> (an_q[0].an_en == $past(strap_sync_q[STRAP_P1_AN]))
            && (an_q[1].force_100 == $past(strap_sync_q[STRAP_P2_SPEED]))
            && (an_q[0].adv_pause == $past(strap_sync_q[STRAP_PAUSE]))
            && an_q[0].adv_100fd && an_q[1].adv_100hd;
    endproperty

    a_diff_high_sel: assert property (
        ce && tx_high_prio[0] && rate_q[0][RATE_DIFF_BIT]
        |=> tx_rate_sel[0].use_high)
        else $error("high packet did not use high counters");

    a_nodiff_low_sel: assert property (
        ce && !rate_q[1][RATE_DIFF_BIT]
        |=> !tx_rate_sel[1].use_high
            && (tx_rate_sel[1].rate_en == $past(rate_q[1][RATE_LO_EN_BIT])))
        else $error("non differential port did not use low counters");

    a_low_rate_en: assert property (
        ce && !tx_high_prio[2] && rate_q[2][RATE_LO_EN_BIT]
        |=> tx_rate_sel[2].rate_en)
        else $error("low priority limiting not enabled");

    a_high_rate_off: assert property (
        ce && tx_high_prio[0] && rate_q[0][RATE_DIFF_BIT]
        && !rate_q[0][RATE_HI_EN_BIT]
        |=> !tx_rate_sel[0].rate_en)
        else $error("high priority limiting active while disabled");

    a_forced_mode: assert property (
        ce && !an_q[0].an_en |=> phy_mode[0].use_forced_speed
            && phy_mode[0].use_forced_duplex)
        else $error("forced mode not used with negotiation off");

    a_forced_speed: assert property (
        ce && !an_q[1].an_en && an_q[1].force_100
        |=> phy_mode[1].use_forced_speed && phy_mode[1].speed_100)
        else $error("forced 100 Mbit not applied");

    a_failed_duplex: assert property (
        ce && an_q[0].an_en && an_failed[0]
        |=> phy_mode[0].use_forced_duplex)
        else $error("forced duplex not used after failed negotiation");

    a_adv_write: assert property (
        s_p1_an_write |=> an_ctrl[0] == $past(reg_wdata))
        else $error("advertised abilities not taken from register write");

    a_miim_write: assert property (
        ce && config_ready && miim_wr && !reg_wr && miim_port_sel
        |=> an_q[1] == $past(miim_wdata))
        else $error("management write not stored");

    a_strap_load: assert property (p_strap_load)
        else $error("strap values not loaded");

    a_boot_bounded: assert property (
        ce && (state_q == INIT_SYNC1) ##1 ce[*2] |=> config_ready)
        else $error("start-up did not finish in three cycles");

    a_ce_freeze: assert property (
        !ce |=> $stable(rate_q) && $stable(an_q))
        else $error("bank state changed while clock enable was low");

    a_miim_read: assert property (
        ce && miim_rd |=> miim_rdata == $past(an_q[miim_port_sel]))
        else $error("management read returned wrong register value");

endmodule

/* File: link_partner_model.sv */
/*
 * Behavioural link partner seen through the port PHYs: it decides per port
 * whether negotiation fails, from the abilities that the block advertises.
 * Assumes an_ctrl comes from the block on clk and refuse from the bench.
 */
`timescale 1ns/1ps
module link_partner_model (
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    input  wire port_ctrl_pkg::an_ctrl_s [1:0] an_ctrl,
    input  wire logic [1:0]                     refuse,
    output logic [1:0]                          an_failed
);
    import port_ctrl_pkg::*;

    logic [1:0] failed_d;

    always_comb begin
        for (int p = 0; p < NUM_AN_PORTS; p++) begin
            // A partner that refuses, or no common ability, fails the link.
            failed_d[p] = an_ctrl[p].an_en &&
                (refuse[p] || (an_ctrl[p][3:0] == 4'h0));
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            an_failed <= 2'b00;
        end else begin
            an_failed <= failed_d;
        end
    end
endmodule

/* File: tb_port_rate_an_ctrl.sv */
/*
 * Self-checking bench for the rate control and negotiation register bank.
 * Assumes the block and the link partner model run on one 20 MHz clock.
 */
`timescale 1ns/1ps
module tb_port_rate_an_ctrl;
    import port_ctrl_pkg::*;

    logic               clk, reset_n, ce, reg_wr, reg_rd;
    logic               miim_port_sel, miim_wr, miim_rd, config_ready;
    logic [7:0]         reg_addr, reg_wdata, reg_rdata, miim_wdata;
    logic [7:0]         miim_rdata, v;
    logic [6:0]         straps;
    logic [2:0]         tx_high_prio;
    logic [1:0]         an_failed, refuse;
    tx_rate_sel_s [2:0] tx_rate_sel;
    an_ctrl_s [1:0]     an_ctrl;
    phy_mode_s [1:0]    phy_mode;
    int                 n_mismatch, tests_run;
    logic [7:0]         rate_m [3];
    logic [7:0]         an_m [2];

    port_rate_an_ctrl port_rate_an_ctrl_i (
        .clk(clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .miim_port_sel(miim_port_sel),
        .miim_wr(miim_wr), .miim_rd(miim_rd), .miim_wdata(miim_wdata),
        .miim_rdata(miim_rdata),
        .port1_autoneg_strap(straps[STRAP_P1_AN]),
        .port1_speed_strap(straps[STRAP_P1_SPEED]),
        .port1_duplex_strap(straps[STRAP_P1_DPX]),
        .port2_autoneg_strap(straps[STRAP_P2_AN]),
        .port2_speed_strap(straps[STRAP_P2_SPEED]),
        .port2_duplex_strap(straps[STRAP_P2_DPX]),
        .advertise_pause_strap(straps[STRAP_PAUSE]),
        .tx_high_prio(tx_high_prio), .an_failed(an_failed),
        .tx_rate_sel(tx_rate_sel), .an_ctrl(an_ctrl),
        .phy_mode(phy_mode), .config_ready(config_ready));

    link_partner_model link_partner_model_i (
        .clk(clk), .reset_n(reset_n), .an_ctrl(an_ctrl),
        .refuse(refuse), .an_failed(an_failed));

    always #25 clk = ~clk;

    task automatic chk(input string what, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic miim_write(input logic s, input logic [7:0] d);
        @(posedge clk);
        miim_port_sel <= s;
        miim_wdata    <= d;
        miim_wr       <= 1'b1;
        @(posedge clk);
        miim_wr <= 1'b0;
    endtask

    task automatic miim_read(input logic s, output logic [7:0] d);
        @(posedge clk);
        miim_port_sel <= s;
        miim_rd       <= 1'b1;
        @(posedge clk);
        miim_rd <= 1'b0;
        @(negedge clk);
        d = miim_rdata;
    endtask

    // Waits off the clock edge so the ready flag is sampled once settled.
    task automatic wait_ready;
        for (int i = 0; i < 20 && config_ready !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (config_ready !== 1'b1) begin
            n_mismatch++;
            close_out();
        end
        an_m[0] = {straps[STRAP_P1_AN], straps[STRAP_P1_SPEED],
                   straps[STRAP_P1_DPX], straps[STRAP_PAUSE], 4'hf};
        an_m[1] = {straps[STRAP_P2_AN], straps[STRAP_P2_SPEED],
                   straps[STRAP_P2_DPX], straps[STRAP_PAUSE], 4'hf};
    endtask

    task automatic check_an(input int p);
        logic [7:0] e, rd;
        logic [3:0] m;
        e = an_m[p];
        m = {!e[7], !e[7] || (e[7] && (refuse[p] || e[3:0] == 4'h0)),
             e[6], e[5]};
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("an_ctrl", e, an_ctrl[p]);
        chk("phy_mode", {4'h0, m}, {4'h0, phy_mode[p]});
        reg_read(OFS_P1_AN + 8'(p * 16), rd);
        chk("an_reg_read", e, rd);
        miim_read(p[0], rd);
        chk("an_miim_read", e, rd);
    endtask

    task automatic check_rate(input int p);
        logic [7:0] e, rd;
        e = rate_m[p];
        for (int hp = 0; hp < 2; hp++) begin
            @(posedge clk);
            tx_high_prio[p] <= hp[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            if (e[RATE_DIFF_BIT] && hp == 1) begin
                chk("sel_hi", {6'h0, e[RATE_HI_EN_BIT], 1'b1},
                    {6'h0, tx_rate_sel[p]});
            end else begin
                chk("sel_lo", {6'h0, e[RATE_LO_EN_BIT], 1'b0},
                    {6'h0, tx_rate_sel[p]});
            end
        end
        reg_read(OFS_P1_RATE + 8'(p * 16), rd);
        chk("rate_read", e, rd);
    endtask

    initial begin
        void'($urandom(82));
        clk = 1'b0;
        reset_n = 1'b0;
        ce = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {miim_port_sel, miim_wr, miim_rd, miim_wdata} = '0;
        tx_high_prio = 3'h0;
        refuse = 2'b00;
        straps = 7'($urandom);
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        // Straps must win over a write that lands before loading.
        reg_write(OFS_P1_AN, 8'h00);
        wait_ready();
        check_an(0);
        check_an(1);
        for (int p = 0; p < NUM_PORTS; p++) begin
            rate_m[p] = RATE_RESET;
            check_rate(p);
            for (int k = 0; k < 8; k++) begin
                rate_m[p] = {5'($urandom), 3'(k)};
                reg_write(OFS_P1_RATE + 8'(p * 16), rate_m[p]);
                check_rate(p);
            end
        end
        // A low clock enable freezes the bank, so this write must not land.
        @(posedge clk);
        ce <= 1'b0;
        reg_write(OFS_P1_RATE, ~rate_m[0]);
        @(posedge clk);
        ce <= 1'b1;
        check_rate(0);
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            if (i % 5 == 0) v[3:0] = 4'h0;
            refuse = 2'($urandom);
            an_m[i % 2] = v;
            if (i % 4 < 2) reg_write(OFS_P1_AN + 8'((i % 2) * 16), v);
            else miim_write(i[0], v);
            check_an(i % 2);
        end
        fork
            reg_write(OFS_P1_AN, 8'hc3);
            miim_write(1'b0, 8'h3c);
        join
        an_m[0] = 8'hc3;
        check_an(0);
        reg_write(OFS_P3_AN_RSVD, 8'hff);
        reg_read(OFS_P3_AN_RSVD, v);
        chk("rsvd_read", RSVD_READ, v);
        reg_read(8'h55, v);
        chk("unmapped_read", 8'h00, v);
        check_an(1);
        // A reset in mid-run with fresh straps must reload the fields.
        @(posedge clk);
        reset_n <= 1'b0;
        straps  <= ~straps;
        @(negedge clk);
        chk("an_in_reset", AN_RESET, an_ctrl[1]);
        chk("ready_in_reset", 8'h00, {7'h0, config_ready});
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        reg_write(OFS_P2_AN, 8'h00);
        wait_ready();
        check_an(0);
        check_an(1);
        rate_m[1] = RATE_RESET;
        check_rate(1);
        close_out();
    end
endmodule
